// ==== core/sarcs_pkg.sv ====
// constants and types of the sar conversion sequencer
package sarcs_pkg;
    localparam int unsigned CLOCK_HZ          = 40_000_000;
    localparam int unsigned RESOLUTION        = 16;
    // aperture delay in ns; rounded down, at least one cycle
    localparam int unsigned APERTURE_NS       = 25;
    localparam int unsigned APERTURE_CYCLES   = (APERTURE_NS * (CLOCK_HZ / 1_000_000) / 1000) < 1 ? 1 :
                                                (APERTURE_NS * (CLOCK_HZ / 1_000_000) / 1000);
    // cycles between switch opening and array transfer to reference ground
    localparam int unsigned SWITCH_GAP_CYCLES = 1;
    // hold-off before normal mode power-down once idle, in cycles
    localparam int unsigned WAKE_CYCLES       = 2;
    localparam logic [15:0] CODE_ZERO         = 16'h0000;
    localparam logic [15:0] CODE_FULL         = 16'hffff;
    localparam logic [15:0] CODE_MID          = 16'h8000;
    localparam logic [15:0] RESULT_RESET      = 16'h0000;

    typedef enum logic [2:0] {
        SARCS_ACQUIRE,
        SARCS_APERTURE,
        SARCS_SWITCH,
        SARCS_SEARCH,
        SARCS_FINISH
    } sarcs_state_t;
endpackage : sarcs_pkg

// ==== core/sarcs_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sarcs_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             resetn_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : sarcs_sync
`default_nettype wire

// ==== core/sarcs_top.sv ====
// conversion sequencer: acquisition, switch order, binary search, result and busy
`timescale 1ns/1ps
`default_nettype none
module sarcs_top #(
    parameter int unsigned WIDTH = sarcs_pkg::RESOLUTION
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             resetn_in,
    // host pins
    input  wire logic             convert_start_in,
    input  wire logic             fast_mode_in,
    // analog front end
    input  wire logic             comparator_in,
    input  wire logic             over_range_in,
    input  wire logic             under_range_in,
    output var  logic             sample_switch_pos_out,
    output var  logic             sample_switch_neg_out,
    output var  logic             array_to_input_out,
    output var  logic             array_to_reference_ground_out,
    output var  logic [WIDTH-1:0] array_bits_out,
    output var  logic             powered_out,
    // result
    output var  logic [WIDTH-1:0] result_out,
    output var  logic             result_valid_out,
    output var  logic             busy_out
);
    import sarcs_pkg::*;

    logic [2:0] pins_sync;
    logic       start_q;
    logic       fast_q;
    logic       cmp_q;
    logic       over_q;
    logic       under_q;

    // comparator and range flags come from the analog side, so they are synchronised too
    sarcs_sync #(.WIDTH(3)) u_sync_pins (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .async_in  ({convert_start_in, fast_mode_in, comparator_in}),
        .sync_out  (pins_sync)
    );

    sarcs_sync #(.WIDTH(2)) u_sync_range (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .async_in  ({over_range_in, under_range_in}),
        .sync_out  ({over_q, under_q})
    );

    assign fast_q = pins_sync[1];
    assign cmp_q  = pins_sync[0];

    sarcs_state_t     state;
    sarcs_state_t     next_state;
    logic [7:0]       count;
    logic [7:0]       next_count;
    logic [4:0]       bit_index;
    logic [WIDTH-1:0] trial;
    logic             start_prev;
    logic             first_fast;

    wire start_rise = pins_sync[2] & ~start_prev;
    assign start_q = start_rise;
    wire in_acquire  = (state == SARCS_ACQUIRE);
    wire search_last = (state == SARCS_SEARCH) && (bit_index == 5'd0);

    // clamp code from the range flags, else straight binary trial
    wire [WIDTH-1:0] clamp_code = over_q  ? CODE_FULL[WIDTH-1:0] :
                                  under_q ? CODE_ZERO[WIDTH-1:0] :
                                  trial;

    // trial with the current bit kept or dropped by the comparator
    wire [WIDTH-1:0] bit_mask   = {{(WIDTH-1){1'b0}}, 1'b1} << bit_index;
    wire [WIDTH-1:0] keep_trial = cmp_q ? trial : (trial & ~bit_mask);
    wire [WIDTH-1:0] next_bit   = (bit_index == 5'd0) ? {WIDTH{1'b0}} : (bit_mask >> 1);

    // array shows the trial under test: top bit alone first, then each next trial
    wire             load_first = (state == SARCS_SWITCH) && (count == 8'h00);
    wire             show_next  = (state == SARCS_SEARCH) && !search_last;
    wire [WIDTH-1:0] shown_bits = load_first ? CODE_MID[WIDTH-1:0] :
                                  show_next  ? (keep_trial | next_bit) :
                                  {WIDTH{1'b0}};

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            SARCS_ACQUIRE: begin
                // start only honoured in the acquire state; a rise during a conversion is lost
                if (start_q) begin
                    next_state = SARCS_APERTURE;
                    next_count = 8'(APERTURE_CYCLES - 1);
                end
            end
            SARCS_APERTURE: begin
                if (count == 8'h00) begin
                    next_state = SARCS_SWITCH;
                    next_count = 8'(SWITCH_GAP_CYCLES);
                end else begin
                    next_count = count - 8'h01;
                end
            end
            SARCS_SWITCH: begin
                if (count == 8'h00) begin
                    next_state = SARCS_SEARCH;
                end else begin
                    next_count = count - 8'h01;
                end
            end
            SARCS_SEARCH: begin
                if (search_last) begin
                    next_state = SARCS_FINISH;
                end
            end
            SARCS_FINISH: begin
                next_state = SARCS_ACQUIRE;
            end
            default: begin
                next_state = SARCS_ACQUIRE;
            end
        endcase
    end

    // sequencer runs on the local clock only; no serial clock is involved
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state      <= SARCS_ACQUIRE;
            count      <= 8'h00;
            start_prev <= 1'b0;
        end else begin
            state      <= next_state;
            count      <= next_count;
            start_prev <= pins_sync[2];
        end
    end

    // search register: msb first, one bit decided per cycle
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trial     <= CODE_MID[WIDTH-1:0];
            bit_index <= 5'd0;
        end else if (state == SARCS_SWITCH && count == 8'h00) begin
            trial     <= CODE_MID[WIDTH-1:0];
            bit_index <= 5'(WIDTH - 1);
        end else if (state == SARCS_SEARCH) begin
            trial     <= keep_trial | next_bit;
            bit_index <= (bit_index == 5'd0) ? 5'd0 : bit_index - 5'd1;
        end
    end

    // result taken from this conversion only, held until the next finishes
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_out       <= RESULT_RESET[WIDTH-1:0];
            result_valid_out <= 1'b0;
            first_fast       <= 1'b1;
        end else if (state == SARCS_FINISH) begin
            result_out       <= clamp_code;
            // fast mode's first result is meaningless; normal mode's first is good
            result_valid_out <= ~(fast_q & first_fast);
            first_fast       <= ~fast_q;
        end
    end

    // switch control: opens before arrays move to reference ground
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sample_switch_pos_out         <= 1'b1;
            sample_switch_neg_out         <= 1'b1;
            array_to_input_out            <= 1'b1;
            array_to_reference_ground_out <= 1'b0;
            busy_out                      <= 1'b0;
            array_bits_out                <= {WIDTH{1'b0}};
        end else begin
            sample_switch_pos_out         <= (next_state == SARCS_ACQUIRE) ||
                                             (next_state == SARCS_APERTURE);
            sample_switch_neg_out         <= (next_state == SARCS_ACQUIRE) ||
                                             (next_state == SARCS_APERTURE);
            array_to_input_out            <= (next_state == SARCS_ACQUIRE) ||
                                             (next_state == SARCS_APERTURE) ||
                                             (next_state == SARCS_SWITCH && state != SARCS_SWITCH);
            array_to_reference_ground_out <= (next_state == SARCS_SEARCH) ||
                                             (next_state == SARCS_SWITCH && state == SARCS_SWITCH);
            busy_out                      <= (next_state != SARCS_ACQUIRE);
            array_bits_out                <= shown_bits;
        end
    end

    // normal mode powers down while idle; fast mode stays on, for one conversion per 21 cycles (about 1.9 MSPS)
    logic [7:0] wake_count;
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            powered_out <= 1'b0;
            wake_count  <= 8'h00;
        end else if (fast_q || !in_acquire) begin
            powered_out <= 1'b1;
            wake_count  <= 8'(WAKE_CYCLES);
        end else if (wake_count != 8'h00) begin
            wake_count  <= wake_count - 8'h01;
        end else begin
            powered_out <= 1'b0;
        end
    end
endmodule : sarcs_top
`default_nettype wire

// ==== test/sar_conversion_sequencer_tb.sv ====
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_tb;
    import sarcs_pkg::*;
    logic        clock_in, resetn_in, convert_start, fast_mode, comparator, over_range, under_range;
    logic        busy, result_valid, ok, first_fast;
    logic [15:0] result, last, lfsr;
    int          miscompares, n_compared, i;
    sarcs_top i_sarcs_top (.clock_in(clock_in), .resetn_in(resetn_in), .convert_start_in(convert_start),
        .fast_mode_in(fast_mode), .comparator_in(comparator), .over_range_in(over_range),
        .under_range_in(under_range), .sample_switch_pos_out(), .sample_switch_neg_out(), .array_to_input_out(),
        .array_to_reference_ground_out(), .array_bits_out(), .powered_out(), .result_out(result),
        .result_valid_out(result_valid), .busy_out(busy));
    sarcs_host_model i_sarcs_host_model (.clock_in(clock_in), .busy_in(busy), .convert_start_out(convert_start),
        .fast_mode_out(fast_mode), .comparator_out(comparator), .over_range_out(over_range),
        .under_range_out(under_range));
    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : next_rand
    // static comparator keeps or drops every trial bit; over range wins
    function automatic logic [15:0] exp_code(input logic c, o, u);
        return o ? CODE_FULL : (u ? CODE_ZERO : (c ? CODE_FULL : CODE_ZERO));
    endfunction : exp_code
    task automatic check_code(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t code %h expected %h", $time, got, exp);
        end
    endtask : check_code
    task automatic check_flag(input logic got, exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_flag
    task automatic run_conv(input logic f, c, o, u, input int gap);
        repeat (gap) @(negedge clock_in);
        check_code(result, last);
        i_sarcs_host_model.do_conv(f, c, o, u, ok);
        check_flag(ok, 1'b1);
        last = exp_code(c, o, u);
        check_code(result, last);
        check_flag(result_valid, !(f && first_fast));
        first_fast = !f;
    endtask : run_conv
    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    initial begin
        #(25 * 20000);
        miscompares++;
        wrap_up();
    end
    initial begin
        {miscompares, n_compared} = '0;
        resetn_in = 1'b0;
        first_fast = 1'b1;
        last = RESULT_RESET;
        lfsr = 16'd27889;
        repeat (4) @(negedge clock_in);
        resetn_in = 1'b1;
        run_conv(1'b1, 1'b1, 1'b0, 1'b0, 2);
        run_conv(1'b1, 1'b0, 1'b1, 1'b0, 0);
        run_conv(1'b1, 1'b1, 1'b0, 1'b1, 0);
        run_conv(1'b1, 1'b0, 1'b1, 1'b1, 5);
        run_conv(1'b0, 1'b0, 1'b0, 1'b0, 3);
        run_conv(1'b0, 1'b1, 1'b0, 1'b0, 0);
        run_conv(1'b1, 1'b0, 1'b0, 1'b0, 1);
        for (i = 0; i < 60; i++) begin
            lfsr = next_rand(lfsr);
            run_conv(lfsr[0], lfsr[1], lfsr[2] & lfsr[3], lfsr[4] & lfsr[5], int'(lfsr[9:8]));
        end
        wrap_up();
    end
endmodule : sar_conversion_sequencer_tb
`default_nettype wire

// ==== test/sarcs_host_model.sv ====
// host and static front end model driving the sequencer
`timescale 1ns/1ps
`default_nettype none
module sarcs_host_model (
    input  wire logic clock_in,
    input  wire logic busy_in,
    output var  logic convert_start_out,
    output var  logic fast_mode_out,
    output var  logic comparator_out,
    output var  logic over_range_out,
    output var  logic under_range_out
);
    initial {convert_start_out, fast_mode_out, comparator_out, over_range_out, under_range_out} = 5'h00;
    // one conversion; levels settle 3 cycles ahead of the start to cover sync lag
    task automatic do_conv(input logic f, c, o, u, output logic ok);
        int n;
        @(negedge clock_in);
        {fast_mode_out, comparator_out, over_range_out, under_range_out} = {f, c, o, u};
        repeat (3) @(negedge clock_in);
        convert_start_out = 1'b1;
        for (n = 0; n < 20 && busy_in !== 1'b1; n++) @(negedge clock_in);
        ok = (busy_in === 1'b1);
        convert_start_out = 1'b0;
        // no serial clock offered while converting
        for (n = 0; n < 40 && busy_in !== 1'b0; n++) @(negedge clock_in);
        ok = ok && (busy_in === 1'b0);
        comparator_out = ~c;
    endtask : do_conv
endmodule : sarcs_host_model
`default_nettype wire

// ==== test/sarcs_props.sv ====
// port checker of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sarcs_props #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic             clock_in,
    input wire logic             resetn_in,
    input wire logic             convert_start_in,
    input wire logic             fast_mode_in,
    input wire logic             sample_switch_pos_out,
    input wire logic             sample_switch_neg_out,
    input wire logic             array_to_input_out,
    input wire logic             array_to_reference_ground_out,
    input wire logic [WIDTH-1:0] array_bits_out,
    input wire logic             powered_out,
    input wire logic [WIDTH-1:0] result_out,
    input wire logic             busy_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    sequence s_open; $fell(sample_switch_pos_out); endsequence
    sequence s_ground; array_to_reference_ground_out && !array_to_input_out; endsequence
    AST_SWITCH_ORDER: assert property (s_open |-> !array_to_reference_ground_out ##1 s_ground)
        else $error("arrays not grounded after switches opened");
    AST_SWITCH_PAIR: assert property (sample_switch_pos_out == sample_switch_neg_out)
        else $error("sampling switches disagree");
    AST_GROUND_OPEN: assert property (array_to_reference_ground_out |-> !sample_switch_pos_out && !array_to_input_out)
        else $error("grounded array while still sampling");
    AST_MSB_FIRST: assert property ($rose(array_to_reference_ground_out) |-> ##[0:2] array_bits_out == 16'h8000)
        else $error("first trial is not the top bit alone");
    AST_IDLE_BITS: assert property (!busy_out |-> array_bits_out == '0)
        else $error("trial bits outside a conversion");
    AST_START_TAKEN: assert property ($rose(convert_start_in) && !busy_out && sample_switch_pos_out |-> ##[2:8] busy_out)
        else $error("start not taken");
    AST_CONV_SPAN: assert property ($rose(busy_out) |-> ##[16:24] !busy_out)
        else $error("conversion length off");
    AST_RESULT_HELD: assert property (busy_out && $past(busy_out) |-> $stable(result_out))
        else $error("result moved during a conversion");
    AST_FAST_POWER: assert property ($fell(busy_out) && fast_mode_in && $past(fast_mode_in, 4) |-> ##1 powered_out)
        else $error("powered down in fast mode");
    AST_NORMAL_DOWN: assert property ($fell(busy_out) && !fast_mode_in && !$past(fast_mode_in, 4) |-> ##[0:4] !powered_out)
        else $error("no power down in normal mode");
endmodule : sarcs_props
bind sarcs_top sarcs_props #(.WIDTH(WIDTH)) i_sarcs_props (.clock_in(clock_in), .resetn_in(resetn_in),
    .convert_start_in(convert_start_in), .fast_mode_in(fast_mode_in), .sample_switch_pos_out(sample_switch_pos_out),
    .sample_switch_neg_out(sample_switch_neg_out), .array_to_input_out(array_to_input_out),
    .array_to_reference_ground_out(array_to_reference_ground_out), .array_bits_out(array_bits_out),
    .powered_out(powered_out), .result_out(result_out), .busy_out(busy_out));
`default_nettype wire
